// >>> rtl/ctq_top.sv
// transmit queue control and status with apb register access
// assumes attempt events arrive as one-cycle pulses from the protocol engine
// How it works
// - base address marks start of message memory
// - two low base bits read zero
// - depth is depth code plus one
// - size fields writable only in config mode
// - retry code sets attempts when limit enabled
// - priority field ranks queue, 31 highest
// - flush resets queue, hardware clears bit
// - send request starts, clears when drained
// - writing zero while set aborts
// - head advance commits one message slot
// - attempts interrupt enable gates its flag
// - empty and not-full enables gate flags
// - status shows next transmit slot index
// - aborted bit updates on done, abort, reset
// - arbitration lost bit tracks last attempt
// - bus error bit tracks last attempt
// - attempts flag set by hardware, software clears
// - empty flag high when nothing pending
// - not-full flag high while slot free
// - enabled conditions form vector bit zero
module ctq_top #(
  parameter int AW = 8
) (
  input  wire logic              i_clk,
  input  wire logic              i_rst_n,
  input  wire logic              i_psel,
  input  wire logic              i_penable,
  input  wire logic              i_pwrite,
  input  wire logic [AW-1:0]     i_paddr,
  input  wire logic [31:0]       i_pwdata,
  output logic      [31:0]       o_prdata,
  output logic                   o_pready,
  output logic                   o_pslverr,
  input  wire logic [2:0]        i_op_mode_sel,
  input  wire logic              i_retry_limit_enable,
  input  wire ctq_pkg::ctq_ev_t  i_ev,
  output ctq_pkg::ctq_cfg_t      o_cfg,
  output logic                   o_abort,
  output logic                   o_tx_int_pending_vec
);
  logic [15:0] base_r;
  logic [2:0]  pl_r;
  logic [4:0]  depth_r;
  logic [1:0]  retry_r;
  logic [4:0]  pri_r;
  logic        send_r, atie_r, eie_r, nfie_r;
  logic [4:0]  head_r, idx_r;
  logic [5:0]  count_r;
  logic        abt_r, arb_r, err_r, atif_r;
  logic [3:0]  tries_r;
  logic [1:0]  fcnt_r;
  ctq_pkg::ctq_state_t st_r;

  // apb decode, zero-wait answer in the access phase
  wire acc    = i_psel && i_penable;
  wire wr     = acc && i_pwrite;
  wire a_base = i_paddr == AW'(ctq_pkg::OFS_BASE_LO);
  wire a_cfg  = i_paddr == AW'(ctq_pkg::OFS_CFG_HI);
  wire a_ctl  = i_paddr == AW'(ctq_pkg::OFS_CTL_LO);
  wire a_stat = i_paddr == AW'(ctq_pkg::OFS_STAT);
  wire a_link = i_paddr == AW'(ctq_pkg::OFS_LINK);
  wire mapped = a_base || a_cfg || a_ctl || a_stat || a_link;
  wire flushing = st_r == ctq_pkg::CTQ_FLUSH;
  wire cfg_mode = i_op_mode_sel == ctq_pkg::MODE_CONFIG;
  wire w_ctl  = wr && a_ctl;
  wire w_send = i_pwdata[ctq_pkg::CTL_SEND];
  wire adv    = w_ctl && i_pwdata[ctq_pkg::CTL_ADV] && !flushing &&
                (count_r <= {1'b0, depth_r});
  // abort on zero write while set
  wire abort  = w_ctl && !w_send && send_r && !flushing;
  wire flush_req = w_ctl && i_pwdata[ctq_pkg::CTL_FLUSH];
  wire [5:0] slots = {1'b0, depth_r} + 6'h01;
  wire empty  = count_r == 6'h00;
  // not full while a slot is free
  wire nfull  = count_r < slots;
  wire fail   = i_ev.arb_lost || i_ev.bus_err;
  wire no_retry = i_retry_limit_enable && retry_r == ctq_pkg::RETRY_NONE;
  wire three  = i_retry_limit_enable && retry_r == ctq_pkg::RETRY_THREE;
  wire exhaust = send_r && fail &&
                 (no_retry || (three && tries_r >= ctq_pkg::THREE_TRIES));
  wire done   = send_r && i_ev.done && !empty;
  wire last   = done && count_r == 6'h01 && !adv;
  wire atif_clr = wr && a_stat && i_pwdata[ctq_pkg::ST_ATIF];

  function automatic logic [4:0] nxt(input logic [4:0] p,
                                     input logic [4:0] d);
    nxt = (p == d) ? 5'h00 : p + 5'h01;
  endfunction : nxt

  function automatic logic [6:0] bytes(input logic [2:0] c);
    case (c)
      3'h0: bytes = 7'h08;
      3'h1: bytes = 7'h0C;
      3'h2: bytes = 7'h10;
      3'h3: bytes = 7'h14;
      3'h4: bytes = 7'h18;
      3'h5: bytes = 7'h20;
      3'h6: bytes = 7'h30;
      default: bytes = 7'h40;
    endcase
  endfunction : bytes

  // read data mux
  logic [31:0] rd;
  always_comb begin
    rd = 32'h0000_0000;
    if (a_base) rd[15:0] = base_r;
    if (a_cfg)  rd[15:0] = {pl_r, depth_r, 1'b0, retry_r, pri_r};
    if (a_ctl)  rd[15:0] = {5'h00, flushing, send_r, 1'b0, 1'b1, 2'h0,
                           atie_r, 1'b0, eie_r, 1'b0, nfie_r};
    if (a_stat) rd[15:0] = {3'h0, idx_r, abt_r, arb_r, err_r, atif_r,
                           1'b0, empty, 1'b0, nfull};
    if (a_link) rd[0] = o_tx_int_pending_vec;
  end

  // bus outputs registered
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_prdata  <= 32'h0000_0000;
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
    end else begin
      o_pready  <= i_psel && !i_penable;
      o_pslverr <= i_psel && !i_penable && !mapped;
      o_prdata  <= (i_psel && !i_penable) ? rd : 32'h0000_0000;
    end
  end

  // configuration registers
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      base_r  <= 16'h0000;
      pl_r    <= 3'h0;
      depth_r <= 5'h00;
      retry_r <= ctq_pkg::RETRY_RST;
      pri_r   <= 5'h00;
      atie_r  <= 1'b0;
      eie_r   <= 1'b0;
      nfie_r  <= 1'b0;
    end else begin
      if (wr && a_base) base_r <= {i_pwdata[15:2], 2'b00};
      if (wr && a_cfg) begin
        retry_r <= i_pwdata[ctq_pkg::CFG_RETRY_LSB +: 2];
        pri_r   <= i_pwdata[ctq_pkg::CFG_PRI_LSB +: 5];
        if (cfg_mode) begin
          pl_r    <= i_pwdata[ctq_pkg::CFG_PL_LSB +: 3];
          depth_r <= i_pwdata[ctq_pkg::CFG_DEPTH_LSB +: 5];
        end
      end
      if (w_ctl) begin
        atie_r <= i_pwdata[ctq_pkg::CTL_ATIE];
        eie_r  <= i_pwdata[ctq_pkg::CTL_EIE];
        nfie_r <= i_pwdata[ctq_pkg::CTL_NFIE];
      end
    end
  end

  // queue state machine: idle, sending, flushing
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_r    <= ctq_pkg::CTQ_IDLE;
      fcnt_r  <= 2'h0;
      send_r  <= 1'b0;
      head_r  <= 5'h00;
      idx_r   <= 5'h00;
      count_r <= 6'h00;
      tries_r <= 4'h0;
      abt_r   <= 1'b0;
      arb_r   <= 1'b0;
      err_r   <= 1'b0;
    end else begin
      case (st_r)
        ctq_pkg::CTQ_FLUSH: begin
          fcnt_r <= fcnt_r - 2'h1;
          if (fcnt_r == 2'h1) st_r <= ctq_pkg::CTQ_IDLE;
        end
        default: begin
          if (flush_req) begin
            st_r    <= ctq_pkg::CTQ_FLUSH;
            fcnt_r  <= ctq_pkg::FLUSH_CYC;
            send_r  <= 1'b0;
            head_r  <= 5'h00;
            idx_r   <= 5'h00;
            count_r <= 6'h00;
            tries_r <= 4'h0;
            abt_r   <= 1'b0;
          end else begin
            if (adv) head_r <= nxt(head_r, depth_r);
            count_r <= count_r + {5'h00, adv} - {5'h00, done};
            if (send_r && (fail || i_ev.done)) begin
              arb_r <= i_ev.arb_lost;
              err_r <= i_ev.bus_err;
            end
            if (fail && send_r) tries_r <= tries_r + 4'h1;
            if (done) begin
              idx_r   <= nxt(idx_r, depth_r);
              tries_r <= 4'h0;
              abt_r   <= 1'b0;
            end
            if (w_ctl && w_send) send_r <= 1'b1;
            else if (abort || last || exhaust) send_r <= 1'b0;
            if (abort || exhaust) begin
              abt_r   <= 1'b1;
              tries_r <= 4'h0;
            end
            st_r <= (w_ctl && w_send) ? ctq_pkg::CTQ_SEND
                    : (abort || last || exhaust) ? ctq_pkg::CTQ_IDLE
                    : st_r;
          end
        end
      endcase
    end
  end

  // sticky attempts flag, set wins over clear
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) atif_r <= 1'b0;
    else if (exhaust) atif_r <= 1'b1;
    else if (atif_clr) atif_r <= 1'b0;
  end

  // engine-facing outputs
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_cfg   <= '0;
      o_abort <= 1'b0;
      o_tx_int_pending_vec <= 1'b0;
    end else begin
      o_cfg.base       <= base_r;
      o_cfg.slot_bytes <= bytes(pl_r);
      o_cfg.depth_sel  <= depth_r;
      o_cfg.tx_priority <= pri_r;
      o_cfg.index      <= idx_r;
      o_cfg.send       <= send_r;
      o_abort          <= abort;
      o_tx_int_pending_vec <= (atie_r && atif_r) || (eie_r && empty) ||
                              (nfie_r && nfull);
    end
  end

  AST_IDX_RANGE: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    idx_r <= depth_r) else $error("index beyond depth");
  AST_BASE_ALIGN: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    base_r[1:0] == 2'b00) else $error("base not aligned");
  AST_FLUSH_CLR: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    flush_req && !flushing |=> flushing [*2] ##1 !flushing)
    else $error("flush did not clear");
  AST_ATIF_SET: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    exhaust |=> atif_r) else $error("attempts flag not set");
  AST_ABORT: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    abort && !flush_req |=> !send_r && abt_r)
    else $error("abort ignored");
  AST_EMPTY: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    $fell(count_r == 6'h00) |-> $past(adv)) else $error("bad fill");
  AST_DRAIN: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    last && !flush_req && !(w_ctl && w_send) |=> !send_r && empty)
    else $error("send not cleared");
  AST_CFG_LOCK: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !cfg_mode |=> $stable(depth_r)) else $error("depth changed");
  AST_INT: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    eie_r && empty |=> o_tx_int_pending_vec)
    else $error("empty int missing");

  // high from the first edge after reset, when output copies are loaded
  logic run_r;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) run_r <= 1'b0;
    else run_r <= 1'b1;
  end

  // steps of a queue update shared by the checks below
  sequence s_commit;
    adv && !flush_req;
  endsequence
  sequence s_success;
    done && !flush_req && !abort && !fail;
  endsequence
  sequence s_retry_fail;
    send_r && fail && !w_ctl && !flush_req && !i_ev.done;
  endsequence

  // head, count and index movement
  AST_HEAD: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    s_commit ##0 (head_r != depth_r) |=> head_r == $past(head_r) + 5'h01)
    else $error("head did not step");
  AST_HWRAP: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    s_commit ##0 (head_r == depth_r) |=> head_r == 5'h00)
    else $error("head did not wrap");
  AST_CNT_UP: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    s_commit ##0 !done |=> count_r == $past(count_r) + 6'h01)
    else $error("commit not counted");
  AST_IDX_S: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    s_success ##0 (idx_r != depth_r) |=> idx_r == $past(idx_r) + 5'h01)
    else $error("index did not step");
  AST_IWRAP: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    s_success ##0 (idx_r == depth_r) |=> idx_r == 5'h00)
    else $error("index did not wrap");
  AST_FULL: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    w_ctl && i_pwdata[ctq_pkg::CTL_ADV] && !nfull && !flushing &&
    !flush_req && !done |=> count_r == $past(count_r))
    else $error("advance taken while full");

  // attempt outcome status
  AST_OK_ABT: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    s_success |=> !abt_r)
    else $error("aborted bit after success");
  AST_OK_BUS: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    s_success |=> !arb_r && !err_r)
    else $error("fault bits after success");
  AST_ARB: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    send_r && i_ev.arb_lost && !flush_req |=> arb_r)
    else $error("arbitration loss missed");
  AST_ERR: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    send_r && i_ev.bus_err && !flush_req |=> err_r)
    else $error("bus error missed");

  // retry policy, send request and sticky flag
  AST_NORTY: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    s_retry_fail ##0 (i_retry_limit_enable && retry_r == 2'h0)
    |=> !send_r && atif_r)
    else $error("retry not refused");
  AST_UNLIM: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    s_retry_fail ##0 !i_retry_limit_enable |=> send_r)
    else $error("send dropped without limit");
  AST_UNLIM2: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    s_retry_fail ##0 retry_r[1] |=> send_r)
    else $error("unlimited retry stopped");
  AST_SEND: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    w_ctl && w_send && !flushing && !flush_req |=> send_r)
    else $error("send request lost");
  AST_ATCLR: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    atif_clr && !exhaust |=> !atif_r)
    else $error("attempts flag not cleared");

  // interrupt vector bit
  AST_VEC_AT: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    atie_r && atif_r |=> o_tx_int_pending_vec)
    else $error("attempts int missing");
  AST_VEC_NF: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    nfie_r && nfull |=> o_tx_int_pending_vec)
    else $error("not-full int missing");
  AST_VEC_0: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !atie_r && !eie_r && !nfie_r |=> !o_tx_int_pending_vec)
    else $error("int without enable");

  // engine-facing copies of the settings
  AST_O_BASE: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    run_r |-> o_cfg.base == $past(base_r))
    else $error("base copy wrong");
  AST_O_PRI: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    run_r |-> o_cfg.tx_priority == $past(pri_r))
    else $error("priority copy wrong");
  AST_O_DEP: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    run_r |-> o_cfg.depth_sel == $past(depth_r))
    else $error("depth copy wrong");
  AST_PL64: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    run_r && $past(pl_r) == 3'h7 |-> o_cfg.slot_bytes == 7'h40)
    else $error("payload 64 wrong");
  AST_PL8: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    run_r && $past(pl_r) == 3'h0 |-> o_cfg.slot_bytes == 7'h08)
    else $error("payload 8 wrong");
endmodule : ctq_top

// >>> shared/ctq_pkg.sv
// constants, register map and carrier types for the transmit queue block
// assumes an apb slave in a 100 MHz single-clock system
package ctq_pkg;
  // register byte offsets on apb
  localparam logic [7:0] OFS_BASE_LO = 8'h00;
  localparam logic [7:0] OFS_CFG_HI  = 8'h04;
  localparam logic [7:0] OFS_CTL_LO  = 8'h08;
  localparam logic [7:0] OFS_STAT    = 8'h0C;
  localparam logic [7:0] OFS_LINK    = 8'h10;
  // configuration field positions
  localparam int CFG_PL_LSB    = 13;
  localparam int CFG_DEPTH_LSB = 8;
  localparam int CFG_RETRY_LSB = 5;
  localparam int CFG_PRI_LSB   = 0;
  // control field positions
  localparam int CTL_FLUSH   = 10;
  localparam int CTL_SEND    = 9;
  localparam int CTL_ADV     = 8;
  localparam int CTL_TXDIR   = 7;
  localparam int CTL_ATIE    = 4;
  localparam int CTL_EIE     = 2;
  localparam int CTL_NFIE    = 0;
  // status field positions
  localparam int ST_IDX_LSB  = 8;
  localparam int ST_ABT      = 7;
  localparam int ST_ARB      = 6;
  localparam int ST_ERR      = 5;
  localparam int ST_ATIF     = 4;
  localparam int ST_EIF      = 2;
  localparam int ST_NFIF     = 0;
  // reset value, mode and retry codes
  localparam logic [1:0] RETRY_RST   = 2'h3;
  localparam logic [2:0] MODE_CONFIG = 3'h4;
  localparam logic [1:0] RETRY_NONE  = 2'h0;
  localparam logic [1:0] RETRY_THREE = 2'h1;
  localparam logic [3:0] THREE_TRIES = 4'h3;
  // flush sequence takes this many cycles in the busy state
  localparam logic [1:0] FLUSH_CYC   = 2'h2;

  typedef enum logic [1:0] {
    CTQ_IDLE  = 2'b00,
    CTQ_SEND  = 2'b01,
    CTQ_FLUSH = 2'b10
  } ctq_state_t;

  // outcome of one attempt reported by the protocol engine
  typedef struct packed {
    logic done;     // attempt finished successfully
    logic arb_lost; // attempt lost arbitration
    logic bus_err;  // attempt hit a bus error
  } ctq_ev_t;

  // queue settings presented to the engine and memory mapper
  typedef struct packed {
    logic [15:0] base;
    logic [6:0]  slot_bytes;
    logic [4:0]  depth_sel;
    logic [4:0]  tx_priority;
    logic [4:0]  index;
    logic        send;
  } ctq_cfg_t;
endpackage : ctq_pkg

// >>> test/ctq_node_model.sv
// far-side bus node model: answers send requests with attempt outcomes
// assumes o_cfg and o_abort of ctq_top, gap of two cycles or more
module ctq_node_model (
  input  wire logic              i_clk,
  input  wire logic              i_rst_n,
  input  wire ctq_pkg::ctq_cfg_t i_cfg,
  input  wire logic              i_abort,
  input  wire logic [1:0]        i_fail,
  input  wire logic [3:0]        i_gap,
  output ctq_pkg::ctq_ev_t       o_ev
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] wait_r;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wait_r <= 4'h0;
      o_ev   <= '0;
    end else begin
      o_ev <= '0;
      if (!i_cfg.send || i_abort || o_ev != 3'h0) begin
        wait_r <= 4'h0;
      end else if (wait_r == i_gap) begin
        wait_r <= 4'h0;
        o_ev   <= {i_fail == 2'h0, i_fail == 2'h1, i_fail == 2'h2};
      end else begin
        wait_r <= wait_r + 4'h1;
      end
    end
  end
endmodule : ctq_node_model

// >>> test/ctq_top_test.sv
// self-checking bench for the transmit queue block
// assumes ctq_top answers apb with one wait-free access phase
module ctq_top_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst_n, psel, pen, pwr, pready, slv, rle, abort, vec, rslv;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [2:0] mode;
  logic [1:0] fail;
  logic [3:0] gap;
  ctq_pkg::ctq_ev_t ev;
  ctq_pkg::ctq_cfg_t cfg;
  int err_total, tests_run, ab_cnt, ev_cnt;
  logic [6:0] tbl [8] = '{7'h08, 7'h0C, 7'h10, 7'h14,
                          7'h18, 7'h20, 7'h30, 7'h40};

  ctq_top u_ctq_top (.i_clk(clk), .i_rst_n(rst_n), .i_psel(psel),
    .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(slv), .i_op_mode_sel(mode),
    .i_retry_limit_enable(rle), .i_ev(ev), .o_cfg(cfg),
    .o_abort(abort), .o_tx_int_pending_vec(vec));
  ctq_node_model u_ctq_node_model (.i_clk(clk), .i_rst_n(rst_n),
    .i_cfg(cfg), .i_abort(abort), .i_fail(fail), .i_gap(gap),
    .o_ev(ev));

  // event and abort pulse counters
  always @(posedge clk) begin
    if (abort === 1'b1) ab_cnt++;
    if (ev != 3'h0) ev_cnt++;
  end

  task automatic chk(input logic [31:0] got, exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // one apb transfer, held until pready is seen
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      err_total++;
      $display("unexpected at %0t: no pready", $time);
    end
    rdat = prdata;
    rslv = slv;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb

  task automatic rdc(input logic [7:0] a, input logic [31:0] m, e);
    apb(1'b0, a, 32'h0);
    chk(rdat & m, e);
  endtask : rdc

  // poll a control bit until it reads zero
  task automatic poll(input int b);
    int n;
    n = 0;
    do begin
      apb(1'b0, ctq_pkg::OFS_CTL_LO, 32'h0);
      n++;
    end while (rdat[b] !== 1'b0 && n < 60);
    chk(rdat[b], 1'b0);
  endtask : poll

  task automatic send(input int adv);
    repeat (adv) apb(1'b1, ctq_pkg::OFS_CTL_LO, 32'h0100);
    apb(1'b1, ctq_pkg::OFS_CTL_LO, 32'h0200);
    poll(ctq_pkg::CTL_SEND);
  endtask : send

  task automatic flush();
    apb(1'b1, ctq_pkg::OFS_CTL_LO, 32'h0400);
    poll(ctq_pkg::CTL_FLUSH);
  endtask : flush

  task automatic vchk(input logic e);
    repeat (3) @(negedge clk);
    chk(vec, e);
  endtask : vchk

  task automatic t_reset();
    rdc(ctq_pkg::OFS_CFG_HI, 32'hFFFF, 32'h0060);
    rdc(ctq_pkg::OFS_CTL_LO, 32'hFFFF, 32'h0080);
    rdc(ctq_pkg::OFS_STAT, 32'hFFFF, 32'h0005);
    rdc(8'h14, 32'hFFFFFFFF, 32'h0);
    chk(rslv, 1'b1);
    apb(1'b1, ctq_pkg::OFS_BASE_LO, 32'hFFFF);
    rdc(ctq_pkg::OFS_BASE_LO, 32'hFFFFFFFF, 32'hFFFC);
    chk(cfg.base, 16'hFFFC);
  endtask : t_reset

  task automatic t_cfg();
    for (int c = 0; c < 8; c++) begin
      apb(1'b1, ctq_pkg::OFS_CFG_HI, (c << 13) | 32'h1F);
      repeat (2) @(negedge clk);
      chk(cfg.slot_bytes, tbl[c]);
      chk(cfg.tx_priority, 5'h1F);
    end
    mode <= 3'h0;
    apb(1'b1, ctq_pkg::OFS_CFG_HI, 32'h1F00);
    rdc(ctq_pkg::OFS_CFG_HI, 32'hFF00, 32'hE000);
    mode <= ctq_pkg::MODE_CONFIG;
  endtask : t_cfg

  task automatic t_queue();
    apb(1'b1, ctq_pkg::OFS_CFG_HI, 32'h0260);
    repeat (4) apb(1'b1, ctq_pkg::OFS_CTL_LO, 32'h0100);
    rdc(ctq_pkg::OFS_STAT, 32'h5, 32'h0);
    send(0);
    rdc(ctq_pkg::OFS_STAT, 32'h1F85, 32'h0005);
    send(2);
    rdc(ctq_pkg::OFS_STAT, 32'h1F85, 32'h0205);
    send(2);
    rdc(ctq_pkg::OFS_STAT, 32'h1F85, 32'h0105);
    repeat (2) apb(1'b1, ctq_pkg::OFS_CTL_LO, 32'h0100);
    flush();
    rdc(ctq_pkg::OFS_STAT, 32'h1F05, 32'h0005);
  endtask : t_queue

  task automatic t_abort();
    gap <= 4'hF;
    apb(1'b1, ctq_pkg::OFS_CTL_LO, 32'h0100);
    apb(1'b1, ctq_pkg::OFS_CTL_LO, 32'h0200);
    apb(1'b1, ctq_pkg::OFS_CTL_LO, 32'h0000);
    repeat (3) @(negedge clk);
    chk(ab_cnt, 1);
    rdc(ctq_pkg::OFS_STAT, 32'h80, 32'h80);
    gap <= 4'h2;
    flush();
  endtask : t_abort

  task automatic t_fail();
    rle <= 1'b1;
    fail <= 2'h1;
    apb(1'b1, ctq_pkg::OFS_CFG_HI, 32'h0220);
    ev_cnt = 0;
    apb(1'b1, ctq_pkg::OFS_CTL_LO, 32'h0110);
    apb(1'b1, ctq_pkg::OFS_CTL_LO, 32'h0210);
    poll(ctq_pkg::CTL_SEND);
    chk(ev_cnt, 4);
    rdc(ctq_pkg::OFS_STAT, 32'hD0, 32'hD0);
    vchk(1'b1);
    apb(1'b1, ctq_pkg::OFS_CTL_LO, 32'h0);
    vchk(1'b0);
    apb(1'b1, ctq_pkg::OFS_STAT, 32'h10);
    rdc(ctq_pkg::OFS_STAT, 32'h10, 32'h0);
    flush();
    fail <= 2'h2;
    apb(1'b1, ctq_pkg::OFS_CFG_HI, 32'h0200);
    ev_cnt = 0;
    send(1);
    chk(ev_cnt, 1);
    rdc(ctq_pkg::OFS_STAT, 32'h60, 32'h20);
    flush();
    apb(1'b1, ctq_pkg::OFS_CTL_LO, 32'h4);
    vchk(1'b1);
    apb(1'b1, ctq_pkg::OFS_CTL_LO, 32'h0);
    vchk(1'b0);
    apb(1'b1, ctq_pkg::OFS_CTL_LO, 32'h1);
    vchk(1'b1);
  endtask : t_fail

  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : summarize

  // clock source
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // watchdog against a hang
  initial begin
    repeat (30000) @(posedge clk);
    err_total++;
    summarize();
  end

  // reset, then scenarios in order
  initial begin
    {rst_n, psel, pen, pwr, rle, paddr, pwdata} = '0;
    mode = ctq_pkg::MODE_CONFIG;
    fail = 2'h0;
    gap = 4'h2;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_cfg();
    t_queue();
    t_abort();
    t_fail();
    summarize();
  end
endmodule : ctq_top_test
